// *** design/fsp_pkg.sv ***
package fsp_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_POINTER     = 8'h04;
  localparam logic [7:0] ADDR_DATA        = 8'h08;
  localparam logic [7:0] ADDR_STORE_CMD   = 8'h0C;
  localparam logic [7:0] ADDR_LOAD_CMD    = 8'h10;
  localparam logic [7:0] ADDR_LOAD_RESULT = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h18;

  // ****************************************************************
  // Command codes in the low five control bits
  // ****************************************************************
  localparam logic [4:0] CMD_BUFFER_LOAD = 5'h01;
  localparam logic [4:0] CMD_PAGE_ERASE  = 5'h03;
  localparam logic [4:0] CMD_PAGE_WRITE  = 5'h05;
  localparam logic [4:0] CMD_FUSE_READ   = 5'h09;
  localparam logic [4:0] CMD_BUF_CLEAR   = 5'h11;
  localparam logic [4:0] CTRL_RESET      = 5'h00;

  // ****************************************************************
  // Pointer fields and fuse/lock selectors
  // ****************************************************************
  localparam int PAGE_LSB = 6;
  localparam int PAGE_MSB = 12;
  localparam int WORD_LSB = 1;
  localparam int WORD_MSB = 5;
  localparam int PAGE_W   = PAGE_MSB - PAGE_LSB + 1;
  localparam int WORD_W   = WORD_MSB - WORD_LSB + 1;
  localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK      = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [2:0] STORE_WINDOW  = 3'h4;
  localparam logic [2:0] LOAD_WINDOW   = 3'h3;
  localparam int CLK_PERIOD_NS         = 20;
  localparam int PROG_MIN_NS           = 3200000;
  localparam int PROG_MAX_NS           = 3400000;
  localparam int PROG_CYCLES           = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES       = PROG_MAX_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic buffer_clear_request;
    logic fuse_lock_read_select;
    logic page_write_select;
    logic page_erase_select;
    logic self_program_enable;
  } fsp_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } fsp_ahb_req_t;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10
  } fsp_op_t;

endpackage

// *** design/fsp_page_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buffer #(
  parameter int WORDS = 32,
  parameter int WIDTH = 16
) (
  // Clock and system reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Control
  input  wire logic                        clear,
  input  wire logic                        load_en,
  input  wire logic [$clog2(WORDS)-1:0]    load_idx,
  input  wire logic [WIDTH-1:0]            load_data,
  // Contents
  output logic      [WORDS-1:0][WIDTH-1:0] page,
  output logic                             any_loaded
);

  if (WORDS < 2 || WIDTH < 1) $error("page buffer geometry unsupported");

  logic [WIDTH-1:0] mem [WORDS];
  logic [WORDS-1:0] valid_q;
  logic [WORDS-1:0] valid_d;

  // Valid bits: any word order is accepted, clear wins over a load
  always_comb
  begin
    valid_d = valid_q;
    if (clear)
      valid_d = '0;
    else if (load_en)
      valid_d[load_idx] = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      valid_q <= '0;
    else
      valid_q <= valid_d;
  end

  // Data words need no reset; an invalid word reads as erased
  always_ff @(posedge clk)
  begin
    if (load_en && !clear)
      mem[load_idx] <= load_data;
  end

  // Erased state is all ones, so programming leaves unloaded words alone
  always_comb
  begin
    for (int i = 0; i < WORDS; i++)
      page[i] = valid_q[i] ? mem[i] : '1;
    any_loaded = |valid_q;
  end

endmodule
`default_nettype wire

// *** design/fsp_prog_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsp_prog_timer #(
  parameter int CYCLES = 160000
) (
  // Clock and power-on reset
  input  wire logic clk,
  input  wire logic por_n,
  // Control and status
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  if (CYCLES < 2) $error("programming time too short");

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          run_q;
  logic          run_d;

  // Count down one full programming time per start
  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (run_q)
    begin
      if (cnt_q == '0)
        run_d = 1'b0;
      else
        cnt_d = cnt_q - 1'b1;
    end
    else if (start)
    begin
      run_d = 1'b1;
      cnt_d = LOAD;
    end
  end

  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign busy = run_q;
  assign done = run_q && (cnt_q == '0);

endmodule
`default_nettype wire

// *** design/fsp_sequencer.sv ***
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fsp_sequencer #(
  parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES,
  parameter int FLASH_WORDS = 4096
) (
  // Clock and resets
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        NPOR,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // EEPROM interlock
  input  wire logic        EEPROM_WRITE_BUSY,
  // Fuse and lock bits, a one marks a programmed bit
  input  wire logic [7:0]  FUSE_LOW_BYTE_PROG,
  input  wire logic [7:0]  FUSE_HIGH_BYTE_PROG,
  input  wire logic [7:0]  EXTENDED_FUSE_BYTE_PROG,
  input  wire logic [7:0]  LOCK_BITS_PROG,
  // Core status
  output logic             CORE_STALL,
  output logic             FLASH_BUSY
);

  localparam int PW = fsp_pkg::PAGE_W;
  localparam int WW = fsp_pkg::WORD_W;
  localparam int PAGE_WORDS = 1 << WW;
  localparam int FA = $clog2(FLASH_WORDS);

  if (FLASH_WORDS != (1 << (PW + WW)))
    $error("flash size must match page and word fields");
  if (PROG_CYCLES * fsp_pkg::CLK_PERIOD_NS > fsp_pkg::PROG_MAX_NS)
    $error("programming time beyond its maximum");

  // ****************************************************************
  // Bus address phase
  // ****************************************************************

  fsp_pkg::fsp_ahb_req_t req_q;
  fsp_pkg::fsp_ahb_req_t req_d;
  logic [31:0]           hrdata_q;
  logic [31:0]           hrdata_d;

  // Capture a word-sized NONSEQ or SEQ transfer; other sizes are dropped
  always_comb
  begin
    req_d.valid = HSEL && HREADY && (HTRANS == 2'b10 || HTRANS == 2'b11) && (HSIZE == 3'b010);
    req_d.write = HWRITE;
    req_d.addr  = {HADDR[7:2], 2'b00};
  end

  // ****************************************************************
  // Command state
  // ****************************************************************

  fsp_pkg::fsp_ctrl_t ctrl_q;
  fsp_pkg::fsp_ctrl_t ctrl_d;
  logic [15:0]        ptr_q;
  logic [15:0]        ptr_d;
  logic [15:0]        data_q;
  logic [15:0]        data_d;
  logic [2:0]         win_q;
  logic [2:0]         win_d;
  logic [7:0]         result_q;
  logic [7:0]         result_d;
  logic [15:0]        flash_rd_q;

  fsp_pkg::fsp_op_t   op_q;
  fsp_pkg::fsp_op_t   op_d;
  logic [PW-1:0]      op_page_q;
  logic [PW-1:0]      op_page_d;
  logic               stall_q;
  logic               busy_q;

  logic               wr_ctrl;
  logic               wr_ptr;
  logic               wr_data;
  logic               wr_store;
  logic               wr_load;
  logic               rd_load;
  logic [4:0]         code;
  logic               code_ok;
  logic               store_ok;
  logic               load_ok;
  logic               op_busy;
  logic               op_start;
  logic               timer_done;
  logic               timer_busy;
  logic               buf_clear;
  logic               buf_load;
  logic               buf_any;
  logic [PAGE_WORDS-1:0][15:0] buf_page;

  logic [15:0] flash_mem [FLASH_WORDS];

  // Data-phase strobes, decoded from the captured address
  always_comb
  begin
    wr_ctrl  = req_q.valid && req_q.write && (req_q.addr == fsp_pkg::ADDR_CTRL);
    wr_ptr   = req_q.valid && req_q.write && (req_q.addr == fsp_pkg::ADDR_POINTER);
    wr_data  = req_q.valid && req_q.write && (req_q.addr == fsp_pkg::ADDR_DATA);
    wr_store = req_q.valid && req_q.write && (req_q.addr == fsp_pkg::ADDR_STORE_CMD);
    wr_load  = req_q.valid && req_q.write && (req_q.addr == fsp_pkg::ADDR_LOAD_CMD);
    rd_load  = 1'b0;
    code     = HWDATA[4:0];
  end

  // Only the five documented codes are commands
  function automatic logic is_command(input logic [4:0] c);
    is_command = (c == fsp_pkg::CMD_BUFFER_LOAD) || (c == fsp_pkg::CMD_PAGE_ERASE) ||
                 (c == fsp_pkg::CMD_PAGE_WRITE) || (c == fsp_pkg::CMD_FUSE_READ) ||
                 (c == fsp_pkg::CMD_BUF_CLEAR);
  endfunction

  // Fuse and lock bytes read inverted: programmed is zero
  function automatic logic [7:0] fuse_byte(input logic [15:0] p, input logic [7:0] fl,
                                           input logic [7:0] fh, input logic [7:0] fe,
                                           input logic [7:0] lk);
    case (p)
      fsp_pkg::PTR_FUSE_LOW:  fuse_byte = ~fl;
      fsp_pkg::PTR_LOCK:      fuse_byte = ~lk;
      fsp_pkg::PTR_FUSE_EXT:  fuse_byte = ~fe;
      fsp_pkg::PTR_FUSE_HIGH: fuse_byte = ~fh;
      default:                fuse_byte = 8'hFF;
    endcase
  endfunction

  // Window checks: store within four cycles, load within three
  always_comb
  begin
    op_busy  = (op_q != fsp_pkg::OP_IDLE);
    code_ok  = is_command(code) && !EEPROM_WRITE_BUSY && !op_busy;
    store_ok = wr_store && (win_q != 3'h0) && ctrl_q.self_program_enable && !op_busy;
    load_ok  = wr_load && (win_q > (fsp_pkg::STORE_WINDOW - fsp_pkg::LOAD_WINDOW)) &&
               ctrl_q.fuse_lock_read_select && !EEPROM_WRITE_BUSY;
  end

  // Store effects: buffer load or start of a timed operation
  always_comb
  begin
    buf_load = store_ok && ({ctrl_q} == fsp_pkg::CMD_BUFFER_LOAD);
    op_start = store_ok && (({ctrl_q} == fsp_pkg::CMD_PAGE_ERASE) ||
                            ({ctrl_q} == fsp_pkg::CMD_PAGE_WRITE));
  end

  // Control register, pointer, data pair and command window
  always_comb
  begin
    ctrl_d   = ctrl_q;
    ptr_d    = ptr_q;
    data_d   = data_q;
    win_d    = win_q;
    result_d = result_q;
    if (win_q != 3'h0)
      win_d = win_q - 3'h1;
    if (win_q == 3'h1)
      ctrl_d = fsp_pkg::CTRL_RESET;
    if (wr_ctrl && code_ok)
    begin
      ctrl_d = code;
      win_d  = fsp_pkg::STORE_WINDOW;
    end
    if (wr_ptr)
      ptr_d = HWDATA[15:0];
    if (wr_data)
      data_d = HWDATA[15:0];
    // A store ends the window; enable then reads from the busy engine
    if (store_ok)
    begin
      ctrl_d = fsp_pkg::CTRL_RESET;
      win_d  = 3'h0;
    end
    if (wr_load)
    begin
      if (load_ok)
      begin
        result_d = fuse_byte(ptr_q, FUSE_LOW_BYTE_PROG, FUSE_HIGH_BYTE_PROG,
                             EXTENDED_FUSE_BYTE_PROG, LOCK_BITS_PROG);
        ctrl_d   = fsp_pkg::CTRL_RESET;
        win_d    = 3'h0;
      end
      else
        result_d = ptr_q[0] ? flash_rd_q[15:8] : flash_rd_q[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_q   <= fsp_pkg::CTRL_RESET;
      ptr_q    <= 16'h0000;
      data_q   <= 16'h0000;
      win_q    <= 3'h0;
      result_q <= 8'h00;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      ptr_q    <= ptr_d;
      data_q   <= data_d;
      win_q    <= win_d;
      result_q <= result_d;
    end
  end

  // ****************************************************************
  // Bus read data and response
  // ****************************************************************

  // Read mux uses next values except for the status buffer bit, so a read right after a write sees it
  always_comb
  begin
    hrdata_d = 32'h0000_0000;
    if (req_d.valid && !req_d.write)
    begin
      case (req_d.addr)
        fsp_pkg::ADDR_CTRL:        hrdata_d = {27'h0000000, ctrl_d[4:1],
                                               ctrl_d.self_program_enable | op_busy | op_start};
        fsp_pkg::ADDR_POINTER:     hrdata_d = {16'h0000, ptr_d};
        fsp_pkg::ADDR_DATA:        hrdata_d = {16'h0000, data_d};
        fsp_pkg::ADDR_LOAD_RESULT: hrdata_d = {24'h000000, result_d};
        fsp_pkg::ADDR_STATUS:      hrdata_d = {29'h00000000, buf_any, EEPROM_WRITE_BUSY,
                                               op_busy | op_start};
        default:                   hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      req_q     <= '0;
      hrdata_q  <= 32'h0000_0000;
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end
    else
    begin
      req_q     <= req_d;
      hrdata_q  <= hrdata_d;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  assign HRDATA = hrdata_q;

  // ****************************************************************
  // Temporary page buffer
  // ****************************************************************

  // Clear on request, after a page write, or on EEPROM write while loading
  always_comb
  begin
    buf_clear = (wr_ctrl && code_ok && (code == fsp_pkg::CMD_BUF_CLEAR)) ||
                (timer_done && (op_q == fsp_pkg::OP_WRITE)) ||
                (EEPROM_WRITE_BUSY && buf_any && !op_busy);
  end

  // System reset empties the buffer through its own reset
  fsp_page_buffer #(
    .WORDS     (PAGE_WORDS),
    .WIDTH     (16)
  ) u_buffer (
    .clk       (CLOCK),
    .rst_n     (NRST),
    .clear     (buf_clear),
    .load_en   (buf_load),
    .load_idx  (ptr_q[fsp_pkg::WORD_MSB:fsp_pkg::WORD_LSB]),
    .load_data (data_q),
    .page      (buf_page),
    .any_loaded(buf_any)
  );

  // ****************************************************************
  // Timed flash operation (power-on reset only)
  // ****************************************************************

  // The engine ignores system reset so a running operation completes
  always_comb
  begin
    op_d      = op_q;
    op_page_d = op_page_q;
    case (op_q)
      fsp_pkg::OP_IDLE:
      begin
        if (op_start)
        begin
          op_d      = ({ctrl_q} == fsp_pkg::CMD_PAGE_ERASE) ? fsp_pkg::OP_ERASE : fsp_pkg::OP_WRITE;
          op_page_d = ptr_q[fsp_pkg::PAGE_MSB:fsp_pkg::PAGE_LSB];
        end
      end
      fsp_pkg::OP_ERASE,
      fsp_pkg::OP_WRITE:
      begin
        if (timer_done)
          op_d = fsp_pkg::OP_IDLE;
      end
      default:
        op_d = fsp_pkg::OP_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NPOR)
  begin
    if (!NPOR)
    begin
      op_q      <= fsp_pkg::OP_IDLE;
      op_page_q <= '0;
      stall_q   <= 1'b0;
      busy_q    <= 1'b0;
    end
    else
    begin
      op_q      <= op_d;
      op_page_q <= op_page_d;
      stall_q   <= (op_d != fsp_pkg::OP_IDLE);
      busy_q    <= (op_d != fsp_pkg::OP_IDLE);
    end
  end

  assign CORE_STALL = stall_q;
  assign FLASH_BUSY = busy_q;

  // One programming time, rounded up from the least figure
  fsp_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk    (CLOCK),
    .por_n  (NPOR),
    .start  (op_start),
    .busy   (timer_busy),
    .done   (timer_done)
  );

  // ****************************************************************
  // Program flash array
  // ****************************************************************

  // Erase sets a page to ones; programming can only clear bits
  always_ff @(posedge CLOCK)
  begin
    if (timer_done && timer_busy)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
      begin
        if (op_q == fsp_pkg::OP_ERASE)
          flash_mem[{op_page_q, WW'(i)}] <= 16'hFFFF;
        else if (op_q == fsp_pkg::OP_WRITE)
          flash_mem[{op_page_q, WW'(i)}] <= flash_mem[{op_page_q, WW'(i)}] & buf_page[i];
      end
    end
    flash_rd_q <= flash_mem[ptr_d[FA:1]];
  end

  logic unused_ok;
  assign unused_ok = rd_load & ^HADDR[31:8] & ^HADDR[1:0] & ^HWDATA[31:16] & ^ptr_q[15:13];

endmodule
`default_nettype wire

// *** testbench/fsp_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsp_seq_checker #(
  parameter int PROG_CYCLES = 20
) (
  // Clock and resets
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic        NPOR,
  // Bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Core status
  input wire logic        CORE_STALL,
  input wire logic        FLASH_BUSY
);
  // ****************
  // Helper logic
  // ****************
  logic       tk_d;
  logic       rd_d;
  logic       rd_q;
  logic       st_d;
  logic       st_q;
  logic [7:0] ad_d;
  logic [7:0] ad_q;
  int         run_d;
  int         run_q;

  // Taken address phases, and the length of the current busy run
  always_comb
  begin
    tk_d  = HSEL && HREADY && HTRANS[1] && (HSIZE == 3'h2);
    rd_d  = tk_d && !HWRITE;
    st_d  = tk_d && HWRITE && (HADDR[7:0] == fsp_pkg::ADDR_STORE_CMD);
    ad_d  = HADDR[7:0];
    run_d = FLASH_BUSY ? run_q + 1 : 0;
  end

  // Bus trackers follow system reset
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rd_q <= 1'b0;
      st_q <= 1'b0;
      ad_q <= 8'h00;
    end
    else
    begin
      rd_q <= rd_d;
      st_q <= st_d;
      ad_q <= ad_d;
    end
  end

  // The run counter survives system reset, as the engine does
  always_ff @(posedge CLOCK or negedge NPOR)
  begin
    if (!NPOR)
      run_q <= 0;
    else
      run_q <= run_d;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  // Read data phase at one address, busy steady over the whole read
  sequence s_busy_read(a);
    rd_q && (ad_q == a) && FLASH_BUSY && $past(FLASH_BUSY);
  endsequence

  chk_stall_busy: assert property (disable iff (!NPOR) CORE_STALL == FLASH_BUSY)
    else $error("Core stall differs from flash busy");
  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("Bus response not OKAY");
  chk_ready_high: assert property ($past(NRST) |-> HREADYOUT)
    else $error("Ready low outside reset");
  chk_busy_length: assert property (disable iff (!NPOR) $fell(FLASH_BUSY) |-> run_q == PROG_CYCLES)
    else $error("Flash operation length wrong");
  chk_busy_start: assert property (disable iff (!NPOR) $rose(FLASH_BUSY) |-> $past(st_q))
    else $error("Flash operation began without a store");
  chk_ctrl_busy: assert property (s_busy_read(fsp_pkg::ADDR_CTRL) |-> HRDATA[0])
    else $error("Enable bit low during operation");
  chk_status_busy: assert property (s_busy_read(fsp_pkg::ADDR_STATUS) |-> HRDATA[0])
    else $error("Status busy low during operation");
  chk_unmapped_zero: assert property (rd_q && (ad_q > 8'h18) |-> HRDATA == 32'h0)
    else $error("Unmapped read not zero");
endmodule

bind fsp_sequencer fsp_seq_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .CLOCK(CLOCK), .NRST(NRST), .NPOR(NPOR), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .CORE_STALL(CORE_STALL), .FLASH_BUSY(FLASH_BUSY)
);
`default_nettype wire

// *** testbench/fsp_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsp_core_model (
  // Clock
  input  wire logic        CLOCK,
  // Bus master side
  output logic             HSEL,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [31:0]      HWDATA,
  input  wire logic        HREADY,
  input  wire logic [31:0] HRDATA
);
  // Last read answer, announced to the bench watcher
  logic [31:0] rd_data;
  event        rd_done;

  // Idle bus from time zero
  initial
  begin
    HSEL   = 1'b1;
    HADDR  = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE  = 3'h2;
    HWDATA = 32'h0;
  end

  // One word transfer; entered right after an edge, so calls run back to back
  // and a command never loses its short window to a gap
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    HADDR  <= {24'h0, a};
    HWRITE <= wr;
    HTRANS <= 2'h2;
    HWDATA <= ~HWDATA; // Stale data must not pass for valid
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    rd_data = HRDATA;
    if (!wr)
      -> rd_done;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_flash_self_program_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_sequencer;
  localparam int PC = 20;
  typedef struct {logic [7:0] a; logic [31:0] e;} fsp_note_t;

  logic             clock = 1'b0;
  logic             nrst = 1'b0;
  logic             npor = 1'b0;
  logic             ee = 1'b0;
  logic [7:0]       fz [4] = '{default: 8'h00};
  logic [4:0]       bad [3] = '{5'h07, 5'h1F, 5'h02};
  logic [15:0]      dat [32];
  logic [6:0]       pg;
  wire logic        hsel, hwrite, hready, hresp, stall, busy;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  fsp_note_t        notes [$];
  int               fails = 0;
  int               num_checks = 0;

  // 50 MHz clock
  always #10 clock = ~clock;

  fsp_sequencer #(.PROG_CYCLES(PC), .FLASH_WORDS(4096)) u_dut (
    .CLOCK(clock), .NRST(nrst), .NPOR(npor), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .EEPROM_WRITE_BUSY(ee), .FUSE_LOW_BYTE_PROG(fz[0]),
    .FUSE_HIGH_BYTE_PROG(fz[3]), .EXTENDED_FUSE_BYTE_PROG(fz[2]), .LOCK_BITS_PROG(fz[1]),
    .CORE_STALL(stall), .FLASH_BUSY(busy)
  );
  fsp_core_model u_core (
    .CLOCK(clock), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata)
  );

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_core.xfer(1'b1, a, d);
  endtask

  // Note the expected word, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{a, e});
    u_core.xfer(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input logic [4:0] c, input logic [15:0] p);
    wr(fsp_pkg::ADDR_POINTER, {16'h0, p});
    wr(fsp_pkg::ADDR_CTRL, {27'h0, c});
    wr(fsp_pkg::ADDR_STORE_CMD, 32'h0);
  endtask

  // Bounded wait; a status or control read afterwards proves the end
  task automatic wait_op();
    repeat (2) @(posedge clock);
    for (int i = 0; i < PC + 8 && busy === 1'b1; i++)
      @(posedge clock);
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watcher: each read answer against the oldest note
  always @(u_core.rd_done)
  begin
    fsp_note_t n;
    n = notes.pop_front();
    num_checks++;
    if (u_core.rd_data !== n.e)
    begin
      fails++;
      $display("Error read 0x%h: expected %h, seen %h", n.a, n.e, u_core.rd_data);
    end
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("Error watchdog: expected end of tests, seen timeout");
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h247C));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    npor <= 1'b1;
    @(posedge clock);
    rd(fsp_pkg::ADDR_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    foreach (fz[i])
      fz[i] <= 8'($urandom());
    $display("Test reset done");
    // Fuse and lock bytes come back inverted
    for (int p = 0; p < 4; p++)
    begin
      wr(fsp_pkg::ADDR_POINTER, p);
      wr(fsp_pkg::ADDR_CTRL, {27'h0, fsp_pkg::CMD_FUSE_READ});
      wr(fsp_pkg::ADDR_LOAD_CMD, 32'h0);
      rd(fsp_pkg::ADDR_LOAD_RESULT, {24'h0, ~fz[p]});
      rd(fsp_pkg::ADDR_CTRL, 32'h0);
    end
    foreach (bad[i])
    begin
      wr(fsp_pkg::ADDR_CTRL, {27'h0, bad[i]});
      rd(fsp_pkg::ADDR_CTRL, 32'h0);
    end
    // Enable lapses after four idle cycles, a late store does nothing
    wr(fsp_pkg::ADDR_CTRL, {27'h0, fsp_pkg::CMD_BUFFER_LOAD});
    repeat (5) @(posedge clock);
    rd(fsp_pkg::ADDR_CTRL, 32'h0);
    wr(fsp_pkg::ADDR_STORE_CMD, 32'h0);
    rd(fsp_pkg::ADDR_STATUS, 32'h0);
    $display("Test fuse and codes done");
    // Erase with junk outside the page field, then fill out of order
    pg = 7'($urandom());
    cmd(fsp_pkg::CMD_PAGE_ERASE, {3'h5, pg, 6'h2A});
    @(posedge clock);
    rd(fsp_pkg::ADDR_CTRL, 32'h1);
    cmd(fsp_pkg::CMD_BUFFER_LOAD, 16'h0);
    rd(fsp_pkg::ADDR_STATUS, 32'h1);
    // The core must see the stall while the erase is timing
    num_checks++;
    if (stall !== 1'b1)
    begin
      fails++;
      $display("Error core stall: expected 1, seen %b", stall);
    end
    wait_op();
    rd(fsp_pkg::ADDR_CTRL, 32'h0);
    for (int w = 31; w >= 0; w--)
    begin
      dat[w] = 16'($urandom());
      wr(fsp_pkg::ADDR_DATA, {16'h0, dat[w]});
      cmd(fsp_pkg::CMD_BUFFER_LOAD, {3'h0, pg, 5'(w), 1'b0});
    end
    rd(fsp_pkg::ADDR_STATUS, 32'h4);
    cmd(fsp_pkg::CMD_PAGE_WRITE, {3'h0, pg, 6'h00});
    wait_op();
    rd(fsp_pkg::ADDR_STATUS, 32'h0);
    for (int b = 0; b < 64; b++)
    begin
      wr(fsp_pkg::ADDR_POINTER, {19'h0, pg, 6'(b)});
      rd(fsp_pkg::ADDR_STATUS, 32'h0);
      wr(fsp_pkg::ADDR_LOAD_CMD, 32'h0);
      rd(fsp_pkg::ADDR_LOAD_RESULT, {24'h0, b[0] ? dat[b / 2][15:8] : dat[b / 2][7:0]});
    end
    $display("Test page program done");
    // EEPROM activity drops loaded words and blocks commands
    cmd(fsp_pkg::CMD_BUFFER_LOAD, 16'h0006);
    rd(fsp_pkg::ADDR_STATUS, 32'h4);
    ee <= 1'b1;
    @(posedge clock);
    rd(fsp_pkg::ADDR_STATUS, 32'h2);
    cmd(fsp_pkg::CMD_PAGE_ERASE, 16'h0040);
    @(posedge clock);
    rd(fsp_pkg::ADDR_STATUS, 32'h2);
    ee <= 1'b0;
    cmd(fsp_pkg::CMD_BUFFER_LOAD, 16'h0004);
    wr(fsp_pkg::ADDR_CTRL, {27'h0, fsp_pkg::CMD_BUF_CLEAR});
    rd(fsp_pkg::ADDR_STATUS, 32'h0);
    // System reset mid-erase: buffer lost, erase runs on
    cmd(fsp_pkg::CMD_BUFFER_LOAD, 16'h0002);
    cmd(fsp_pkg::CMD_PAGE_ERASE, {3'h0, ~pg, 6'h00});
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(fsp_pkg::ADDR_STATUS, 32'h1);
    wait_op();
    rd(fsp_pkg::ADDR_STATUS, 32'h0);
    $display("Test interlock and reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
